/* verilog/prs_pkg.sv */
// shared constants for the program counter and return stack block
package prs_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] PRS_OFF_PC_LOW = 8'h00;
  localparam logic [7:0] PRS_OFF_HIGH_LATCH = 8'h04;
  localparam logic [7:0] PRS_OFF_UPPER_LATCH = 8'h08;
  localparam logic [7:0] PRS_OFF_STACK_INDEX = 8'h0c;
  localparam logic [7:0] PRS_OFF_TOP_LOW = 8'h10;
  localparam logic [7:0] PRS_OFF_TOP_HIGH = 8'h14;
  localparam logic [7:0] PRS_OFF_TOP_UPPER = 8'h18;
  localparam logic [7:0] PRS_OFF_CTRL = 8'h1c;
  // field positions
  localparam int PRS_IDX_FULL_BIT = 5;
  localparam int PRS_IDX_UNF_BIT = 6;
  localparam int PRS_IDX_OVF_BIT = 7;
  localparam int PRS_CTRL_RUN_BIT = 0;
  // widths and sizes
  localparam int PRS_PC_W = 21;
  localparam int PRS_PTR_W = 5;
  localparam int PRS_WORD_W = 16;
  localparam int PRS_DEPTH = 31;
  localparam logic [4:0] PRS_PTR_TOP = 5'h1f;
  localparam logic [4:0] PRS_PTR_RST = 5'h00;
  // reset values and fixed numbers
  localparam logic PRS_RUN_RST = 1'b0;
  localparam logic [20:0] PRS_PC_RST = 21'h000000;
  localparam logic [20:0] PRS_PC_STEP = 21'h000002;
  localparam logic [20:0] PRS_INT_VECTOR = 21'h000008;
  localparam logic [1:0] PRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRS_RESP_SLVERR = 2'h2;
  // instruction class in the top nibble of the fetched word
  typedef enum logic [3:0] {
    PRS_OP_NOP = 4'h0,
    PRS_OP_ABS_BRANCH = 4'h1,
    PRS_OP_ABS_CALL = 4'h2,
    PRS_OP_REL_CALL = 4'h3,
    PRS_OP_RETURN = 4'h4,
    PRS_OP_EXIT_LIT = 4'h5,
    PRS_OP_INT_EXIT = 4'h6
  } prs_op_t;
  // quadrature phase of the instruction cycle
  typedef enum logic [1:0] {
    PRS_PH_ONE = 2'b00,
    PRS_PH_TWO = 2'b01,
    PRS_PH_THREE = 2'b10,
    PRS_PH_FOUR = 2'b11
  } prs_phase_t;
endpackage

/* verilog/prs_sequencer.sv */
// program counter, return stack and instruction timing core
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - 21-bit counter, only low byte accessible
// - low byte write loads upper bytes from latches
// - low byte read copies upper bytes to latches
// - bit zero held low except after a return to an odd top entry written by software, step by two
// - calls and branch load counter directly
// - 31 entries of 21 bits, 5-bit pointer
// - push on call or interrupt, pop on exits
// - calls and exits leave latches alone
// - push increments pointer then writes entry
// - pop reads entry then decrements pointer
// - reset clears pointer, zero has no entry
// - full, overflow and underflow status flags
// - software reads/writes pointer and top entry
// - top entry seen as three byte registers
// - clock divided into four phases
// - counter advances phase one, opcode latched four
// - fetch overlaps execute, jumps cost two cycles
// - operand read phase two, write phase four
module prs_sequencer
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // register bus, axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // program memory fetch path
  output logic [20:0] fetchAddr,
  input wire logic [15:0] fetchData,
  // interrupt acknowledge from the interrupt controller
  input wire logic intAck,
  // phase and execution strobes
  output logic phaseOne,
  output logic phaseTwo,
  output logic phaseThree,
  output logic phaseFour,
  output logic [15:0] execOpcode,
  output logic operandRead,
  output logic destWrite,
  output logic [7:0] literalOut,
  output logic literalValid,
  output logic stackFull
);

  // all state of the block in one record
  typedef struct packed {
    prs_phase_t phase;
    logic run;
    logic [20:0] pc;
    logic skipInc;
    logic [7:0] highLatch;
    logic [4:0] upperLatch;
    logic [4:0] ptr;
    logic ovf;
    logic unf;
    // 31 words; pointer zero owns no word
    logic [30:0][20:0] stack;
    logic [15:0] prefetch;
    logic [20:0] prefAddr;
    logic prefValid;
    logic [15:0] opcode;
    logic [20:0] execAddr;
    logic execValid;
    logic intPend;
    logic [7:0] literal;
    logic literalValid;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } prs_state_t;

  // reset image: pointer zero, phase one, first fetch from zero
  localparam prs_state_t PRS_STATE_RST = '{
    phase: PRS_PH_ONE,
    run: PRS_RUN_RST,
    pc: PRS_PC_RST,
    skipInc: 1'b1,
    ptr: PRS_PTR_RST,
    bresp: PRS_RESP_OKAY,
    rresp: PRS_RESP_OKAY,
    default: '0
  };

  prs_state_t cur_q; // registered state
  prs_state_t nxt_d; // next state

  logic wrTake; // write address and data taken together
  logic rdTake; // read address taken
  logic execSlot; // phase four of a running core
  logic [20:0] topEntry; // entry under the pointer, zero at index 0
  logic [20:0] relTarget; // relative call destination
  logic [20:0] absTarget; // absolute call or branch destination
  logic [11:0] imm; // immediate field of the opcode

  // bus writes wait out phase four so they never race execution
  assign execSlot = cur_q.run && (cur_q.phase == PRS_PH_FOUR);
  assign wrTake = s_axi_awvalid && s_axi_wvalid && !cur_q.bvalid &&
                  !execSlot;
  assign rdTake = s_axi_arvalid && !cur_q.rvalid;
  // address and data only ever taken together at one edge
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid = cur_q.bvalid;
  assign s_axi_bresp = cur_q.bresp;
  assign s_axi_rvalid = cur_q.rvalid;
  assign s_axi_rresp = cur_q.rresp;
  assign s_axi_rdata = cur_q.rdata;

  // outputs straight from the state record
  assign fetchAddr = cur_q.pc;
  assign phaseOne = cur_q.phase == PRS_PH_ONE;
  assign phaseTwo = cur_q.phase == PRS_PH_TWO;
  assign phaseThree = cur_q.phase == PRS_PH_THREE;
  assign phaseFour = cur_q.phase == PRS_PH_FOUR;
  assign execOpcode = cur_q.opcode;
  assign literalOut = cur_q.literal;
  assign literalValid = cur_q.literalValid;
  assign stackFull = cur_q.ptr == PRS_PTR_TOP;

  // data strobes only for a live, unflushed instruction
  assign operandRead = cur_q.run && cur_q.execValid &&
                       (cur_q.phase == PRS_PH_TWO);
  assign destWrite = execSlot && cur_q.execValid;

  // index zero owns no storage, so it reads back as zero
  assign topEntry = (cur_q.ptr == PRS_PTR_RST) ? PRS_PC_RST :
                    cur_q.stack[cur_q.ptr - 5'h01];
  // branch targets come from the low twelve opcode bits
  assign imm = cur_q.opcode[11:0];
  assign absTarget = {8'h00, imm, 1'b0};
  // relative offset counts words, hence the extra zero bit
  assign relTarget = cur_q.execAddr + PRS_PC_STEP +
                     {{8{imm[11]}}, imm, 1'b0};

  // next-state logic: phases, execution, then the register bus
  always_comb begin
    nxt_d = cur_q;
    // literal strobe lasts one clock only
    nxt_d.literalValid = 1'b0;
    // quadrature divider runs from reset on
    nxt_d.phase = prs_phase_t'(cur_q.phase + 2'h1);
    // hold a pending acknowledge until a phase four takes it
    if (intAck) begin
      nxt_d.intPend = 1'b1;
    end

    if (cur_q.run && cur_q.phase == PRS_PH_ONE) begin
      // execute stage takes the word fetched last cycle
      nxt_d.opcode = cur_q.prefetch;
      nxt_d.execAddr = cur_q.prefAddr;
      nxt_d.execValid = cur_q.prefValid;
      // a fresh load is fetched as is, otherwise step on
      if (cur_q.skipInc) begin
        nxt_d.skipInc = 1'b0;
      end else begin
        nxt_d.pc = {cur_q.pc[20:1] + 20'h00001, 1'b0};
      end
    end

    if (execSlot) begin
      // fetch stage: the word at the counter enters the pipe
      nxt_d.prefetch = fetchData;
      nxt_d.prefAddr = cur_q.pc;
      nxt_d.prefValid = 1'b1;
      if (cur_q.execValid) begin
        unique case (prs_op_t'(cur_q.opcode[15:12]))
          PRS_OP_ABS_BRANCH: begin
            // latches untouched on a direct load
            nxt_d.pc = absTarget;
            nxt_d.skipInc = 1'b1;
            nxt_d.prefValid = 1'b0;
          end
          PRS_OP_ABS_CALL, PRS_OP_REL_CALL: begin
            if (cur_q.ptr == PRS_PTR_TOP) begin
              // no room: flag it, pointer stays put
              nxt_d.ovf = 1'b1;
            end else begin
              // pointer first, then the following address
              nxt_d.ptr = cur_q.ptr + 5'h01;
              nxt_d.stack[cur_q.ptr] = cur_q.execAddr + PRS_PC_STEP;
            end
            // destination loaded directly, latches kept
            nxt_d.pc = (cur_q.opcode[15:12] == PRS_OP_REL_CALL) ?
                       relTarget : absTarget;
            nxt_d.skipInc = 1'b1;
            nxt_d.prefValid = 1'b0;
          end
          PRS_OP_RETURN, PRS_OP_EXIT_LIT, PRS_OP_INT_EXIT: begin
            if (cur_q.ptr == PRS_PTR_RST) begin
              // empty stack: flag it, resume from zero
              nxt_d.unf = 1'b1;
              nxt_d.pc = PRS_PC_RST;
            end else begin
              // entry read first, pointer lowered after
              nxt_d.pc = topEntry;
              nxt_d.ptr = cur_q.ptr - 5'h01;
            end
            if (cur_q.opcode[15:12] == PRS_OP_EXIT_LIT) begin
              nxt_d.literal = cur_q.opcode[7:0];
              nxt_d.literalValid = 1'b1;
            end
            nxt_d.skipInc = 1'b1;
            nxt_d.prefValid = 1'b0;
          end
          default: begin
            // plain instruction: pipeline just flows
            nxt_d.skipInc = cur_q.skipInc;
          end
        endcase
      end
      // acknowledge is taken only where no jump happened
      if (cur_q.intPend && nxt_d.prefValid) begin
        if (cur_q.ptr == PRS_PTR_TOP) begin
          // full: return address lost, vector still taken
          nxt_d.ovf = 1'b1;
        end else begin
          // return to the word whose fetch is now discarded
          nxt_d.ptr = cur_q.ptr + 5'h01;
          nxt_d.stack[cur_q.ptr] = cur_q.pc;
        end
        // vector fetch restarts the pipe from scratch
        nxt_d.pc = PRS_INT_VECTOR;
        nxt_d.skipInc = 1'b1;
        nxt_d.prefValid = 1'b0;
        nxt_d.intPend = intAck;
      end
    end

    // write response handshake
    if (cur_q.bvalid && s_axi_bready) begin
      nxt_d.bvalid = 1'b0;
    end
    // register writes; only byte lane zero carries data
    if (wrTake) begin
      nxt_d.bvalid = 1'b1;
      nxt_d.bresp = PRS_RESP_OKAY;
      unique case (s_axi_awaddr)
        PRS_OFF_PC_LOW: begin
          if (s_axi_wstrb[0]) begin
            // whole counter loads, pipe restarts there
            nxt_d.pc = {cur_q.upperLatch, cur_q.highLatch,
                        s_axi_wdata[7:1], 1'b0};
            nxt_d.skipInc = 1'b1;
            nxt_d.prefValid = 1'b0;
            nxt_d.execValid = 1'b0;
          end
        end
        PRS_OFF_HIGH_LATCH: begin
          if (s_axi_wstrb[0]) begin
            nxt_d.highLatch = s_axi_wdata[7:0];
          end
        end
        PRS_OFF_UPPER_LATCH: begin
          if (s_axi_wstrb[0]) begin
            nxt_d.upperLatch = s_axi_wdata[4:0];
          end
        end
        PRS_OFF_STACK_INDEX: begin
          if (s_axi_wstrb[0]) begin
            // flags clear on a written zero, never set by software
            nxt_d.ptr = s_axi_wdata[4:0];
            nxt_d.ovf = nxt_d.ovf & s_axi_wdata[PRS_IDX_OVF_BIT];
            nxt_d.unf = nxt_d.unf & s_axi_wdata[PRS_IDX_UNF_BIT];
          end
        end
        PRS_OFF_TOP_LOW, PRS_OFF_TOP_HIGH, PRS_OFF_TOP_UPPER: begin
          // index zero has no entry to write
          if (s_axi_wstrb[0] && cur_q.ptr != PRS_PTR_RST) begin
            if (s_axi_awaddr == PRS_OFF_TOP_LOW) begin
              nxt_d.stack[cur_q.ptr - 5'h01][7:0] =
                s_axi_wdata[7:0];
            end else if (s_axi_awaddr == PRS_OFF_TOP_HIGH) begin
              nxt_d.stack[cur_q.ptr - 5'h01][15:8] =
                s_axi_wdata[7:0];
            end else begin
              nxt_d.stack[cur_q.ptr - 5'h01][20:16] =
                s_axi_wdata[4:0];
            end
          end
        end
        PRS_OFF_CTRL: begin
          if (s_axi_wstrb[0]) begin
            nxt_d.run = s_axi_wdata[PRS_CTRL_RUN_BIT];
          end
        end
        default: begin
          // unmapped address
          nxt_d.bresp = PRS_RESP_SLVERR;
        end
      endcase
    end

    // read data handshake
    if (cur_q.rvalid && s_axi_rready) begin
      nxt_d.rvalid = 1'b0;
    end
    // register reads; upper bits read as zero
    if (rdTake) begin
      nxt_d.rvalid = 1'b1;
      nxt_d.rresp = PRS_RESP_OKAY;
      nxt_d.rdata = 32'h00000000;
      unique case (s_axi_araddr)
        PRS_OFF_PC_LOW: begin
          // reading the low byte snapshots the upper two
          nxt_d.rdata[7:0] = cur_q.pc[7:0];
          nxt_d.highLatch = cur_q.pc[15:8];
          nxt_d.upperLatch = cur_q.pc[20:16];
        end
        PRS_OFF_HIGH_LATCH: begin
          nxt_d.rdata[7:0] = cur_q.highLatch;
        end
        PRS_OFF_UPPER_LATCH: begin
          nxt_d.rdata[4:0] = cur_q.upperLatch;
        end
        PRS_OFF_STACK_INDEX: begin
          nxt_d.rdata[4:0] = cur_q.ptr;
          nxt_d.rdata[PRS_IDX_FULL_BIT] = stackFull;
          nxt_d.rdata[PRS_IDX_UNF_BIT] = cur_q.unf;
          nxt_d.rdata[PRS_IDX_OVF_BIT] = cur_q.ovf;
        end
        PRS_OFF_TOP_LOW: begin
          // pointer zero reads back zero through topEntry
          nxt_d.rdata[7:0] = topEntry[7:0];
        end
        PRS_OFF_TOP_HIGH: begin
          nxt_d.rdata[7:0] = topEntry[15:8];
        end
        PRS_OFF_TOP_UPPER: begin
          nxt_d.rdata[4:0] = topEntry[20:16];
        end
        PRS_OFF_CTRL: begin
          nxt_d.rdata[PRS_CTRL_RUN_BIT] = cur_q.run;
        end
        default: begin
          nxt_d.rresp = PRS_RESP_SLVERR;
        end
      endcase
    end
  end

  // one register stage for the whole record
  // reset branch loads only the constant image
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= PRS_STATE_RST;
    end else begin
      cur_q <= nxt_d;
    end
  end

endmodule

/* verification/prs_prog_mem.sv */
// program memory model answering core fetches
`timescale 1ns/1ps
module prs_prog_mem (
  input wire logic [20:0] addr,
  output logic [15:0] data
);
  // 64 words, loaded by the bench before reset ends
  logic [15:0] rom [64];
  // combinational read; the core samples it at its phase four edge
  always_comb begin
    data = rom[addr[6:1]];
  end
endmodule

/* verification/prs_sequencer_asserts.sv */
// port level checks of the sequencer
`timescale 1ns/1ps
module prs_sequencer_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [20:0] fetchAddr,
  input wire logic phaseOne,
  input wire logic phaseTwo,
  input wire logic phaseThree,
  input wire logic phaseFour,
  input wire logic operandRead,
  input wire logic destWrite,
  input wire logic literalValid
);
  // one domain, so one clock and one reset for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  phase_hot_a: assert property (
    $onehot({phaseOne, phaseTwo, phaseThree, phaseFour}))
    else $error("phase strobes not one-hot");
  phase_order_a: assert property (
    rst_n && phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour ##1 phaseOne)
    else $error("phase order broken");
  pc_even_a: assert property (!fetchAddr[0])
    else $error("counter bit zero set");
  // outside bus loads and jumps, a step may only follow phase one
  pc_step_a: assert property (
    ($changed(fetchAddr) && fetchAddr == $past(fetchAddr) + 21'h2 &&
     !$past(s_axi_awready) && !$past(phaseFour))
    |-> $past(phaseOne))
    else $error("counter stepped outside phase one");
  op_read_a: assert property (operandRead |-> phaseTwo)
    else $error("operand read outside phase two");
  dest_write_a: assert property (destWrite |-> phaseFour)
    else $error("destination write outside phase four");
  lit_pulse_a: assert property (literalValid |=> !literalValid)
    else $error("literal strobe longer than a cycle");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule
bind prs_sequencer prs_sequencer_asserts chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .fetchAddr(fetchAddr), .phaseOne(phaseOne), .phaseTwo(phaseTwo),
  .phaseThree(phaseThree), .phaseFour(phaseFour),
  .operandRead(operandRead), .destWrite(destWrite),
  .literalValid(literalValid));

/* verification/program_counter_return_stack_tb_top.sv */
// self-checking bench for the sequencer and its program memory
`timescale 1ns/1ps
module program_counter_return_stack_tb_top;
  import prs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, intAck = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, literalValid, stackFull, operandRead, destWrite;
  logic phaseOne, phaseTwo, phaseThree, phaseFour;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, r;
  logic [20:0] fetchAddr;
  logic [15:0] fetchData, execOpcode;
  logic [7:0] literalOut;
  logic [4:0] p;
  int fail_count = 0, num_checks = 0;
  logic [33:0] rq[$]; // expected read results
  logic [7:0] lq[$]; // expected literals
  prs_sequencer uut (.*);
  prs_prog_mem pm (.addr(fetchAddr), .data(fetchData));
  initial forever #20 clk = ~clk;
  task chk(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // write response code
  task chk_resp(input logic [1:0] e, input logic [1:0] g);
    chk({e, 32'h0}, {g, 32'h0});
  endtask
  // exit opcode byte and its literal, side by side
  task chk_lit(input logic [15:0] e, input logic [15:0] g);
    chk({18'h0, e}, {18'h0, g});
  endtask
  // pin level or leftover count
  task chk_pin(input logic [20:0] e, input logic [20:0] g);
    chk({13'h0, e}, {13'h0, g});
  endtask
  task complete_run;
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // offsets above the control register answer with an error code
  function logic [1:0] rsp(input logic [7:0] a);
    return (a > PRS_OFF_CTRL) ? PRS_RESP_SLVERR : PRS_RESP_OKAY;
  endfunction
  // both channels offered at once; response accepted a cycle late
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_awready);
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
    chk_resp(rsp(a), s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  // read; the watcher compares the result
  task rd(input logic [7:0] a, input logic [7:0] v);
    rq.push_back({rsp(a), 24'h0, (rsp(a) == PRS_RESP_OKAY) ? v : 8'h00});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // park pointer and counter, junk the latch, run, maybe interrupt
  task run_at(input logic [20:0] a, input logic [4:0] q, input logic irq);
    wr(PRS_OFF_STACK_INDEX, {27'h0, q});
    wr(PRS_OFF_HIGH_LATCH, {24'h0, a[15:8]});
    wr(PRS_OFF_UPPER_LATCH, {27'h0, a[20:16]});
    wr(PRS_OFF_PC_LOW, {24'h0, a[7:0]});
    wr(PRS_OFF_HIGH_LATCH, 32'h5c);
    wr(PRS_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    intAck <= irq;
    @(posedge clk);
    intAck <= 1'b0;
    repeat (20) @(posedge clk);
    wr(PRS_OFF_CTRL, 32'h0);
  endtask
  // watcher: oldest expectation against each result as it shows
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (literalValid)
      chk_lit({PRS_OP_EXIT_LIT, 4'h0, lq.pop_front()},
              {execOpcode[15:8], literalOut});
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    foreach (pm.rom[i]) pm.rom[i] = 16'h0000;
    pm.rom[0] = 16'h3007; // call to 0x010
    pm.rom[1] = 16'h1001; // branch to itself
    pm.rom[4] = 16'h5077; // interrupt vector: exit with literal
    pm.rom[8] = 16'h505a; // subroutine: exit with literal
    pm.rom[10] = 16'h3fff; // call to itself
    pm.rom[12] = 16'h6000; // interrupt exit
    r = $urandom(32'he416);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(PRS_OFF_STACK_INDEX, 8'h00);
    rd(PRS_OFF_PC_LOW, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h20, 32'hff);
    wr(PRS_OFF_HIGH_LATCH, 32'h12);
    wr(PRS_OFF_UPPER_LATCH, 32'h03);
    wr(PRS_OFF_PC_LOW, 32'h35);
    chk_pin(21'h031234, fetchAddr);
    wr(PRS_OFF_HIGH_LATCH, 32'h00);
    rd(PRS_OFF_PC_LOW, 8'h34);
    rd(PRS_OFF_HIGH_LATCH, 8'h12);
    rd(PRS_OFF_UPPER_LATCH, 8'h03);
    p = r[4:0] | 5'h01;
    wr(PRS_OFF_STACK_INDEX, {27'h0, p});
    wr(PRS_OFF_TOP_LOW, {24'h0, r[15:8]});
    wr(PRS_OFF_TOP_HIGH, {24'h0, r[23:16]});
    wr(PRS_OFF_TOP_UPPER, {27'h0, r[28:24]});
    rd(PRS_OFF_STACK_INDEX, {2'b00, p == 5'h1f, p});
    rd(PRS_OFF_TOP_LOW, r[15:8]);
    rd(PRS_OFF_TOP_HIGH, r[23:16]);
    rd(PRS_OFF_TOP_UPPER, {3'h0, r[28:24]});
    wr(PRS_OFF_STACK_INDEX, 32'h0);
    wr(PRS_OFF_TOP_LOW, 32'h99);
    rd(PRS_OFF_TOP_LOW, 8'h00);
    lq.push_back(8'h5a);
    lq.push_back(8'h77);
    run_at(21'h000000, 5'h00, 1'b1);
    rd(PRS_OFF_STACK_INDEX, 8'h00);
    rd(PRS_OFF_HIGH_LATCH, 8'h5c);
    run_at(21'h000014, 5'h1f, 1'b0);
    chk_pin(21'h000001, {20'h0, stackFull});
    rd(PRS_OFF_STACK_INDEX, 8'hbf);
    lq.push_back(8'h5a);
    run_at(21'h000018, 5'h00, 1'b0);
    rd(PRS_OFF_STACK_INDEX, 8'h40);
    repeat (4) @(posedge clk);
    // every expected result must have shown up by now
    chk_pin(21'h0, 21'(lq.size()));
    chk_pin(21'h0, 21'(rq.size()));
    complete_run();
  end
endmodule
